// >>> rtl/gpio_axil_slave.sv
`default_nettype none
module gpio_axil_slave (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // write channels
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   // read channels
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   // register side
   gpio_regbus_if.slave     rb
);
   typedef struct packed {
      logic        awready, wready, bvalid, arready, rvalid;
      logic [1:0]  bresp, rresp;
      logic        aw_full, w_full, ar_full, wr_en;
      logic [7:0]  waddr, raddr;
      logic [31:0] wdata, rdata;
   } axil_state_t;

   axil_state_t st, next_st;

   always_comb begin
      next_st = st;
      next_st.wr_en = 1'b0;
      if (awvalid && st.awready) begin
         next_st.aw_full = 1'b1;
         next_st.waddr = awaddr;
      end
      // unstrobed lanes read as zero, which leaves those pins unaffected
      if (wvalid && st.wready) begin
         next_st.w_full = 1'b1;
         next_st.wdata = wdata & {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
      end
      if (st.aw_full && st.w_full && !st.bvalid) begin
         next_st.wr_en = 1'b1;
         next_st.bvalid = 1'b1;
         next_st.bresp = rb.wr_err ? gpio_pkg::RESP_SLVERR : gpio_pkg::RESP_OKAY;
         next_st.aw_full = 1'b0;
         next_st.w_full = 1'b0;
      end else if (st.bvalid && bready) begin
         next_st.bvalid = 1'b0;
      end
      if (arvalid && st.arready) begin
         next_st.ar_full = 1'b1;
         next_st.raddr = araddr;
      end
      if (st.ar_full && !st.rvalid) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = rb.rd_data;
         next_st.rresp = rb.rd_err ? gpio_pkg::RESP_SLVERR : gpio_pkg::RESP_OKAY;
         next_st.ar_full = 1'b0;
      end else if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
      end
      // one write and one read in flight; address and data stay put while answered
      next_st.awready = !next_st.aw_full && !next_st.bvalid;
      next_st.wready = !next_st.w_full && !next_st.bvalid;
      next_st.arready = !next_st.ar_full && !next_st.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign awready = st.awready;
   assign wready = st.wready;
   assign bvalid = st.bvalid;
   assign bresp = st.bresp;
   assign arready = st.arready;
   assign rvalid = st.rvalid;
   assign rdata = st.rdata;
   assign rresp = st.rresp;
   assign rb.wr_en = st.wr_en;
   assign rb.wr_addr = st.waddr;
   assign rb.wr_data = st.wdata;
   assign rb.rd_addr = st.raddr;
endmodule
`default_nettype wire

// >>> rtl/gpio_ifs.sv
`default_nettype none
// register access between bus slave and gpio core
interface gpio_regbus_if;
   logic        wr_en;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic        wr_err;
   logic [7:0]  rd_addr;
   logic [31:0] rd_data;
   logic        rd_err;
   modport slave (output wr_en, wr_addr, wr_data, rd_addr, input wr_err, rd_data, rd_err);
   modport regs  (input wr_en, wr_addr, wr_data, rd_addr, output wr_err, rd_data, rd_err);
endinterface

// sampling control and results
interface gpio_sample_if;
   logic       tick;
   logic       strobe_en;
   logic [8:0] strobe_sel;
   logic [8:0] live;
   logic [8:0] sampled;
   logic [8:0] changed;
   logic       done;
   modport sampler (input tick, strobe_en, strobe_sel, output live, sampled, changed, done);
   modport core    (output tick, strobe_en, strobe_sel, input live, sampled, changed, done);
endinterface
`default_nettype wire

// >>> rtl/gpio_msg_top.sv
`default_nettype none
module gpio_msg_top #(
   parameter int unsigned SAMPLE_PERIOD_CYCLES = gpio_pkg::SAMPLE_PERIOD_CYCLES
) (
   // clock, reset, enable
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // axi4-lite write
   input  wire logic        s_axil_awvalid,
   output logic             s_axil_awready,
   input  wire logic [7:0]  s_axil_awaddr,
   input  wire logic        s_axil_wvalid,
   output logic             s_axil_wready,
   input  wire logic [31:0] s_axil_wdata,
   input  wire logic [3:0]  s_axil_wstrb,
   output logic             s_axil_bvalid,
   input  wire logic        s_axil_bready,
   output logic [1:0]       s_axil_bresp,
   // axi4-lite read
   input  wire logic        s_axil_arvalid,
   output logic             s_axil_arready,
   input  wire logic [7:0]  s_axil_araddr,
   output logic             s_axil_rvalid,
   input  wire logic        s_axil_rready,
   output logic [31:0]      s_axil_rdata,
   output logic [1:0]       s_axil_rresp,
   // pads
   input  wire logic [8:0]  pin_in,
   output logic [8:0]       pin_out,
   output logic [8:0]       pin_oe_n,
   output logic [8:0]       pin_pullup_en,
   // report
   output logic             status_event,
   output logic             status_response,
   output logic [8:0]       pin_level_report
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic [8:0]  outval;
      logic [8:0]  dir;
      logic [8:0]  od;
      logic [8:0]  strobe_sel;
      logic        strobe_en;
      logic [8:0]  int_en;
      logic [17:0] tick_cnt;
      logic        tick;
      logic [8:0]  report;
      logic        evt_pend;
      logic        rsp_pend;
      logic        status_event;
      logic        status_response;
      logic [8:0]  pin_out;
      logic [8:0]  pin_oe_n;
      logic [8:0]  pin_pullup_en;
   } core_state_t;

   localparam logic [17:0] TICK_LAST = 18'(SAMPLE_PERIOD_CYCLES - 1);

   localparam core_state_t RESET_STATE = '{
      outval:          gpio_pkg::RST_OUTVAL,
      dir:             gpio_pkg::RST_DIRECTION,
      od:              gpio_pkg::RST_OPEN_DRAIN,
      strobe_sel:      gpio_pkg::RST_STROBE_SEL,
      strobe_en:       gpio_pkg::RST_STROBE_EN,
      int_en:          gpio_pkg::RST_INT_EN,
      tick_cnt:        18'h0_0000,
      tick:            1'b0,
      report:          9'h000,
      evt_pend:        1'b0,
      rsp_pend:        1'b0,
      status_event:    1'b0,
      status_response: 1'b0,
      pin_out:         9'h000,
      pin_oe_n:        9'h1ff,
      pin_pullup_en:   gpio_pkg::RST_OPEN_DRAIN
   };

   core_state_t st, next_st;

   gpio_regbus_if rb ();
   gpio_sample_if sp ();

   ////////////////////////////////////////////////////////////////////////////
   // sub-blocks

   gpio_axil_slave u_bus (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .awvalid (s_axil_awvalid),
      .awready (s_axil_awready),
      .awaddr  (s_axil_awaddr),
      .wvalid  (s_axil_wvalid),
      .wready  (s_axil_wready),
      .wdata   (s_axil_wdata),
      .wstrb   (s_axil_wstrb),
      .bvalid  (s_axil_bvalid),
      .bready  (s_axil_bready),
      .bresp   (s_axil_bresp),
      .arvalid (s_axil_arvalid),
      .arready (s_axil_arready),
      .araddr  (s_axil_araddr),
      .rvalid  (s_axil_rvalid),
      .rready  (s_axil_rready),
      .rdata   (s_axil_rdata),
      .rresp   (s_axil_rresp),
      .rb      (rb.slave)
   );

   gpio_pin_sampler u_sampler (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .pin_raw (pin_in),
      .sp      (sp.sampler)
   );

   assign sp.tick = st.tick;
   assign sp.strobe_en = st.strobe_en;
   assign sp.strobe_sel = st.strobe_sel;

   ////////////////////////////////////////////////////////////////////////////
   // command decode and pad control

   logic [8:0] fld_a;
   logic [8:0] fld_b;
   logic       drive;

   assign fld_a = rb.wr_data[gpio_pkg::FIELD_A_LSB +: 9]; // [R22]
   assign fld_b = rb.wr_data[gpio_pkg::FIELD_B_LSB +: 9]; // [R22]

   always_comb begin
      next_st = st;
      drive = 1'b0;
      next_st.tick = 1'b0;
      next_st.status_event = 1'b0;
      next_st.status_response = 1'b0;

      // free-running 10 ms sample timer
      if (st.tick_cnt >= TICK_LAST) begin // [R18]
         next_st.tick_cnt = 18'h0_0000;
         next_st.tick = 1'b1;
      end else begin
         next_st.tick_cnt = st.tick_cnt + 18'h0_0001;
      end

      if (rb.wr_en) begin
         unique case (rb.wr_addr)
            gpio_pkg::ADDR_OUTVAL: begin
               // a resets, b sets; both at once is the host's fault, set wins
               next_st.outval = (st.outval & ~fld_a) | fld_b; // [R20]
            end
            gpio_pkg::ADDR_DIRECTION: begin
               next_st.dir = (st.dir & ~fld_a) | fld_b; // [R1]
            end
            gpio_pkg::ADDR_DRIVE: begin
               next_st.od = (st.od | fld_a) & ~fld_b; // [R4]
            end
            gpio_pkg::ADDR_SAMPLING: begin
               if (fld_b[0]) begin // [R9]
                  next_st.strobe_en = 1'b1;
               end else if (fld_a[0]) begin
                  next_st.strobe_en = 1'b0;
               end
               next_st.strobe_sel = {(st.strobe_sel[8:1] & ~fld_a[8:1]) | fld_b[8:1], 1'b0}; // [R9]
            end
            gpio_pkg::ADDR_INT_MASK: begin
               next_st.int_en = (st.int_en & ~fld_a) | fld_b; // [R12]
            end
            gpio_pkg::ADDR_STATUS_REQ: begin
               // live synchronised levels: an open-drain low shows as seen
               next_st.report = sp.live; // [R17]
               next_st.rsp_pend = 1'b1;
               next_st.status_response = 1'b1;
            end
            gpio_pkg::ADDR_REPORT: begin
               if (rb.wr_data[gpio_pkg::REPORT_EVT_BIT]) begin
                  next_st.evt_pend = 1'b0;
               end
               if (rb.wr_data[gpio_pkg::REPORT_RSP_BIT]) begin
                  next_st.rsp_pend = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // event after the clear, so a coincident event is never lost
      if (sp.done && |(sp.changed & st.int_en)) begin // [R15]
         next_st.report = sp.sampled; // [R15]
         next_st.evt_pend = 1'b1;
         next_st.status_event = 1'b1;
      end

      for (int i = 0; i < 9; i++) begin
         // pin 0 is forced to input while it is the strobe
         drive = next_st.dir[i] && !(i == 0 && next_st.strobe_en); // [R8]
         // open drain only ever pulls low
         next_st.pin_oe_n[i] = !(drive && (!next_st.od[i] || !next_st.outval[i])); // [R4]
         next_st.pin_out[i] = next_st.od[i] ? 1'b0 : next_st.outval[i]; // [R20]
      end
      next_st.pin_pullup_en = next_st.od; // [R6]
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= RESET_STATE; // [R2] [R5] [R10] [R13]
      end else if (ce) begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read side and write address check

   always_comb begin
      rb.rd_err = 1'b0;
      rb.wr_err = 1'b0;
      unique case (rb.rd_addr)
         gpio_pkg::ADDR_OUTVAL:     rb.rd_data = {23'h00_0000, st.outval};
         gpio_pkg::ADDR_DIRECTION:  rb.rd_data = {23'h00_0000, st.dir};
         gpio_pkg::ADDR_DRIVE:      rb.rd_data = {23'h00_0000, st.od};
         gpio_pkg::ADDR_SAMPLING:   rb.rd_data = {23'h00_0000, st.strobe_sel[8:1], st.strobe_en};
         gpio_pkg::ADDR_INT_MASK:   rb.rd_data = {23'h00_0000, st.int_en};
         gpio_pkg::ADDR_STATUS_REQ: rb.rd_data = {23'h00_0000, sp.live};
         gpio_pkg::ADDR_REPORT:     rb.rd_data = {14'h0000, st.rsp_pend, st.evt_pend, 7'h00, st.report}; // [R19]
         default: begin
            rb.rd_data = 32'h0000_0000;
            rb.rd_err = 1'b1;
         end
      endcase
      unique case (rb.wr_addr)
         gpio_pkg::ADDR_OUTVAL, gpio_pkg::ADDR_DIRECTION, gpio_pkg::ADDR_DRIVE,
         gpio_pkg::ADDR_SAMPLING, gpio_pkg::ADDR_INT_MASK, gpio_pkg::ADDR_STATUS_REQ,
         gpio_pkg::ADDR_REPORT: rb.wr_err = 1'b0;
         default:               rb.wr_err = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign pin_out = st.pin_out;
   assign pin_oe_n = st.pin_oe_n;
   assign pin_pullup_en = st.pin_pullup_en;
   assign status_event = st.status_event;
   assign status_response = st.status_response;
   assign pin_level_report = st.report;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_reset_state;
      $rose(aresetn) |-> st.dir == 9'h000 && &st.pin_oe_n && &st.pin_pullup_en && st.int_en == 9'h000
         && !st.strobe_en;
   endproperty
   a_reset_state: assert property (p_reset_state) // [R2] [R5] [R10] [R13]
      else $error("state after reset is not all-input open-drain masked continuous");

   property p_inputs_released;
      (~st.dir & ~st.pin_oe_n) == 9'h000;
   endproperty
   a_inputs_released: assert property (p_inputs_released) // [R1]
      else $error("an input pin is driven");

   property p_od_only_low;
      (st.od & ~st.pin_oe_n & st.pin_out) == 9'h000;
   endproperty
   a_od_only_low: assert property (p_od_only_low) // [R4]
      else $error("open-drain pin drives high");

   property p_od_pullup;
      (st.od & ~st.pin_pullup_en) == 9'h000;
   endproperty
   a_od_pullup: assert property (p_od_pullup) // [R6]
      else $error("open-drain pin without pullup");

   property p_strobe_pin0;
      st.strobe_en |-> st.pin_oe_n[0];
   endproperty
   a_strobe_pin0: assert property (p_strobe_pin0) // [R8]
      else $error("strobe pin driven in strobed mode");

   property p_event_cause;
      $rose(st.status_event) |-> $past(sp.done && |(sp.changed & st.int_en)) && st.evt_pend;
   endproperty
   a_event_cause: assert property (p_event_cause) // [R15]
      else $error("status event without unmasked change");

   property p_response;
      ce && rb.wr_en && rb.wr_addr == gpio_pkg::ADDR_STATUS_REQ |=>
         st.status_response && st.rsp_pend && (st.report == $past(sp.live) || st.status_event);
   endproperty
   a_response: assert property (p_response) // [R17]
      else $error("status request not answered with live levels");

   property p_tick_range;
      st.tick_cnt <= TICK_LAST && (st.tick -> st.tick_cnt == 18'h0_0000);
   endproperty
   a_tick_range: assert property (p_tick_range) // [R18]
      else $error("sample timer out of range");

   property p_report_layout;
      rb.rd_addr == gpio_pkg::ADDR_REPORT |-> rb.rd_data[8:0] == st.report && rb.rd_data[15:9] == 7'h00;
   endproperty
   a_report_layout: assert property (p_report_layout) // [R19]
      else $error("report read layout wrong");

endmodule
`default_nettype wire

// >>> rtl/gpio_pin_sampler.sv
`default_nettype none
module gpio_pin_sampler (
   // clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       ce,
   // raw pad levels
   input  wire logic [8:0] pin_raw,
   // core side
   gpio_sample_if.sampler  sp
);
   typedef struct packed {
      logic [8:0] sync1, sync2, sampled, changed;
      logic       done;
   } sampler_state_t;

   sampler_state_t st, next_st;
   logic [8:0]     hold;

   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      next_st.sync1 = pin_raw;
      next_st.sync2 = st.sync1;
      // pin 0 is the strobe and is never held itself
      hold = (sp.strobe_en && st.sync2[0]) ? {sp.strobe_sel[8:1], 1'b0} : 9'h000; // [R8]
      if (sp.tick) begin // [R18]
         next_st.sampled = (st.sampled & hold) | (st.sync2 & ~hold);
         next_st.changed = next_st.sampled ^ st.sampled;
         next_st.done = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign sp.live = st.sync2;
   assign sp.sampled = st.sampled;
   assign sp.changed = st.changed;
   assign sp.done = st.done;
endmodule
`default_nettype wire

// >>> rtl/gpio_pkg.sv
// Notes on behaviour
// [R1] direction write: input-select bits make inputs, output-select bits make outputs
// [R2] all nine pins come out of reset as inputs
// [R3] host never selects input and output for one pin together
// [R4] drive write: open-drain bits add pullup, push-pull bits drop it
// [R5] reset leaves every pin open-drain with pullup on
// [R6] open-drain pins keep the pullup on, even as inputs
// [R7] host never selects open drain and push-pull for one pin together
// [R8] strobed mode: pin 0 is input; strobed pins update only while it is low
// [R9] sampling write: bit 0 switches strobed mode, bits 1 to 8 pick pins
// [R10] reset leaves every pin sampled continuously
// [R11] host never selects continuous and strobed for one pin together
// [R12] mask write: unmask bits enable, mask bits disable change interrupts
// [R13] reset masks every change interrupt, so no events appear
// [R14] host never masks and unmasks one pin together
// [R15] unmasked sampled change sends a status event with all nine levels
// [R16] host compares levels with the previous report to find the cause
// [R17] status request answers with observed pin levels, not driven values
// [R18] pins are sampled once every 10 ms
// [R19] report holds pins 7 to 0 in low byte, pin 8 in bit 8
// [R20] output value: set bits force one, reset bits zero, resets to zero
// [R21] host writes the output value before switching a pin to output
// [R22] bit n of every per-pin field is pin n; pin 8 is bit 8
`default_nettype none
package gpio_pkg;
   localparam int unsigned NPINS = 9;
   // register byte addresses
   localparam logic [7:0] ADDR_OUTVAL     = 8'h00;
   localparam logic [7:0] ADDR_DIRECTION  = 8'h04;
   localparam logic [7:0] ADDR_DRIVE      = 8'h08;
   localparam logic [7:0] ADDR_SAMPLING   = 8'h0c;
   localparam logic [7:0] ADDR_INT_MASK   = 8'h10;
   localparam logic [7:0] ADDR_STATUS_REQ = 8'h14;
   localparam logic [7:0] ADDR_REPORT     = 8'h18;
   // command field positions
   localparam int unsigned FIELD_A_LSB    = 0;
   localparam int unsigned FIELD_B_LSB    = 16;
   localparam int unsigned REPORT_EVT_BIT = 16;
   localparam int unsigned REPORT_RSP_BIT = 17;
   // reset values
   localparam logic [8:0] RST_OUTVAL     = 9'h000;
   localparam logic [8:0] RST_DIRECTION  = 9'h000;
   localparam logic [8:0] RST_OPEN_DRAIN = 9'h1ff;
   localparam logic [8:0] RST_STROBE_SEL = 9'h000;
   localparam logic       RST_STROBE_EN  = 1'b0;
   localparam logic [8:0] RST_INT_EN     = 9'h000;
   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // timing
   localparam int unsigned CLK_PERIOD_NS        = 50;
   localparam int unsigned SAMPLE_PERIOD_NS     = 10_000_000;
   localparam int unsigned SAMPLE_PERIOD_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// >>> verif/gpio_pad_world.sv
`default_nettype none
module gpio_pad_world (
   // clock
   input  wire logic       aclk,
   // pad side of the block
   input  wire logic [8:0] pin_out,
   input  wire logic [8:0] pin_oe_n,
   input  wire logic [8:0] pin_pullup_en,
   // outside drivers
   input  wire logic [8:0] ext_en,
   input  wire logic [8:0] ext_val,
   // resolved level
   output logic [8:0]      pin_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] wander = 9'h155;
   // a floating pin wanders, so a stale level never passes for a real one
   always @(posedge aclk) begin
      wander <= ~wander;
   end
   always_comb begin
      for (int i = 0; i < 9; i++) begin
         if (!pin_oe_n[i]) begin
            pin_level[i] = pin_out[i] & (ext_val[i] | ~ext_en[i]); // wired and
         end else if (ext_en[i]) begin
            pin_level[i] = ext_val[i];
         end else begin
            pin_level[i] = pin_pullup_en[i] | wander[i]; // pullup holds the line
         end
      end
   end
endmodule
`default_nettype wire

// >>> verif/message_driven_gpio_block_bench.sv
`default_nettype none
module message_driven_gpio_block_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 0, aresetn = 0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, data;
   logic [8:0]  ext_en = 0, ext_val = 0;
   logic        awready, wready, bvalid, arready, rvalid, status_event, status_response;
   logic [1:0]  bresp, rresp, resp;
   logic [8:0]  pin_in, pin_out, pin_oe_n, pin_pullup_en, pin_level_report;
   int          n_errors = 0, tests_run = 0, evt_cnt = 0, rsp_cnt = 0;
   ////////////////////////////////////////////////////////////////////////
   gpio_msg_top #(.SAMPLE_PERIOD_CYCLES(20)) dut_u (
      .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
      .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_awaddr(awaddr),
      .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_wdata(wdata), .s_axil_wstrb(4'hf),
      .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_bresp(bresp),
      .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_araddr(araddr),
      .s_axil_rvalid(rvalid), .s_axil_rready(rready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en),
      .status_event(status_event), .status_response(status_response),
      .pin_level_report(pin_level_report));
   gpio_pad_world pads_u (.aclk(aclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pin_pullup_en(pin_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_in));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (status_event === 1'b1) evt_cnt <= evt_cnt + 1;
      if (status_response === 1'b1) rsp_cnt <= rsp_cnt + 1;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   // both channels offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= d; bready <= 1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a);
      arvalid <= 1; araddr <= a; rready <= 1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end while (rvalid !== 1'b1);
      data = rdata;
      resp = rresp;
      rready <= 0;
      @(posedge aclk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk($sformatf("reg %h", a), e, data);
      chk("rresp", gpio_pkg::RESP_OKAY, resp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask
   task automatic expect_event(input int lim, input int add, input logic [8:0] lvl);
      int e0;
      e0 = evt_cnt;
      settle(lim);
      chk("event count", e0 + add, evt_cnt);
      if (add != 0) chk("event levels", lvl, pin_level_report);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk("oe_n", 9'h1ff, pin_oe_n);
      chk("pullup", 9'h1ff, pin_pullup_en);
      rc(8'h00, 32'h0000_0000);
      rc(8'h04, 32'h0000_0000);
      rc(8'h08, 32'h0000_01ff);
      rc(8'h0c, 32'h0000_0000);
      rc(8'h10, 32'h0000_0000);
   endtask
   task automatic t_output;
      wr(8'h00, 32'h0105_0000);
      rc(8'h00, 32'h0000_0105);
      wr(8'h08, 32'h0103_0000);
      rc(8'h08, 32'h0000_00fc);
      wr(8'h04, 32'h0107_0000);
      settle(2);
      chk("oe_n", 9'h0fc, pin_oe_n);
      chk("pin_out", 9'h101, pin_out);
      chk("pullup", 9'h0fc, pin_pullup_en);
      wr(8'h00, 32'h0000_0001);
      wr(8'h04, 32'h0000_0002);
      settle(2);
      chk("pin_out", 9'h100, pin_out);
      chk("oe_n", 9'h0fe, pin_oe_n);
   endtask
   // pin 2 is an open-drain one pulled low from outside
   task automatic t_status;
      int r0;
      ext_val <= 9'h1ab;
      ext_en <= 9'h1ff;
      settle(5);
      r0 = rsp_cnt;
      wr(8'h14, 32'h0000_0000);
      settle(3);
      chk("responses", r0 + 1, rsp_cnt);
      chk("status levels", 9'h1aa, pin_level_report);
      rc(8'h18, 32'h0002_01aa);
      wr(8'h18, 32'h0003_0000);
   endtask
   task automatic t_event;
      wr(8'h10, 32'h0120_0000);
      rc(8'h10, 32'h0000_0120);
      wr(8'h10, 32'h0000_0100);
      rc(8'h10, 32'h0000_0020);
      ext_val[3] <= 1'b0;
      expect_event(45, 0, 9'h000);
      ext_val[5] <= 1'b0;
      expect_event(26, 1, 9'h182);
   endtask
   task automatic t_strobe;
      wr(8'h10, 32'h0040_0000);
      wr(8'h0c, 32'h0041_0000);
      rc(8'h0c, 32'h0000_0041);
      settle(2);
      chk("oe_n", 9'h0ff, pin_oe_n);
      ext_val[6] <= 1'b1;
      expect_event(45, 0, 9'h000);
      ext_val[0] <= 1'b0;
      expect_event(26, 1, 9'h1c2);
   endtask
   task automatic t_err;
      wr(8'h1c, 32'h0000_0001);
      chk("bresp", gpio_pkg::RESP_SLVERR, resp);
      rd(8'h1c);
      chk("rresp", gpio_pkg::RESP_SLVERR, resp);
      chk("rdata", 32'h0000_0000, data);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      settle(2);
      t_reset;
      t_output;
      t_status;
      t_event;
      t_strobe;
      t_err;
      end_of_test;
   end
   // the whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge aclk);
      n_errors++;
      end_of_test;
   end
endmodule
`default_nettype wire
